// File: mbsf_handler.sv
// request interpreter of a Modbus TCP server: functions 01..06, exceptions, RTU gateway
// assumes framed PDU bytes in with the unit id alongside, and a byte-wise RTU master
`timescale 1ns/1ps
// Contract
// R1: gateway routing only when own unit id is 255 and serial is RTU master.
// R2: with routing on, unit ids 1 to 247 go to the RTU master.
// R3: unit ids 0 and 255 are served locally from own memory.
// R4: no slave reply before timeout gives an error response to the client.
// R5: addresses, counts and values are 16 bits, high byte first.
// R6: read coils: function, start, count; answer function, byte count, packed bytes.
// R7: first eight bits from start fill first byte, sequence continues onward.
// R8: unused high bits of the final bit byte are zero.
// R9: read discrete inputs is read coils with another code and region.
// R10: read holding registers answers byte count then each register high, low.
// R11: read input registers is read holding with another code and region.
// R12: 32-bit values keep the low half in the lower register.
// R13: write single coil carries bit address and a 16-bit value.
// R14: FF00 sets the coil, 0000 clears it.
// R15: write single register carries register address then value, high first.
// R16: a successful single write answers with an exact copy of the request.
// R17: register write puts low byte at lower address, high byte above it.
// R18: unimplemented function codes get a standard exception response.
module mbsf_handler #(
    parameter int unsigned TIMEOUT_CYC = mbsf_pkg::GW_TIMEOUT_CYC
) (
    // clock and reset
    input logic clock,
    input logic rst,
    // configuration
    input logic [7:0] server_uid,
    input logic rtu_master_mode,
    // request from the client
    input logic req_valid,
    output logic req_ready,
    input mbsf_pkg::mbsf_beat_t req_beat,
    input logic [7:0] req_uid,
    // response to the client
    output logic rsp_valid,
    input logic rsp_ready,
    output mbsf_pkg::mbsf_beat_t rsp_beat,
    // requests handed to the RTU master
    output logic fwd_valid,
    input logic fwd_ready,
    output mbsf_pkg::mbsf_beat_t fwd_beat,
    // slave replies from the RTU master
    input logic rtu_valid,
    output logic rtu_ready,
    input mbsf_pkg::mbsf_beat_t rtu_beat,
    // application access to the marker memory
    input mbsf_pkg::mbsf_wr_t app_wr,
    input logic [mbsf_pkg::MEM_AW-1:0] app_ra,
    output logic [7:0] app_rd
);
    mbsf_pkg::mbsf_regs_t q;
    mbsf_pkg::mbsf_regs_t d;
    mbsf_pkg::mbsf_wr_t mw;
    logic [mbsf_pkg::MEM_AW-1:0] mem_ra;
    logic [7:0] mem_rd;
    logic gw_en;
    logic route;
    logic is_bits;
    logic [7:0] fc;
    logic [15:0] addr;
    logic [15:0] cnt;
    logic [16:0] last_item;
    logic lastbit_w;

    // byte offset of the region that a function works on
    function automatic logic [9:0] region_base(input logic [7:0] f);
        case (f)
            mbsf_pkg::FC_RD_DISC: region_base = mbsf_pkg::DISC_BASE;
            mbsf_pkg::FC_RD_HOLD, mbsf_pkg::FC_WR_REG: region_base = mbsf_pkg::HOLD_BASE;
            mbsf_pkg::FC_RD_INP: region_base = mbsf_pkg::INP_BASE;
            default: region_base = mbsf_pkg::COIL_BASE;
        endcase
    endfunction

    // memory byte holding a bit number
    function automatic logic [9:0] bit_addr(input logic [7:0] f, input logic [15:0] n);
        bit_addr = region_base(f) + {2'h0, n[10:3]};
    endfunction

    // memory byte of one half of a register, low half at the even address
    function automatic logic [9:0] reg_addr(input logic [7:0] f, input logic [15:0] r, input logic hi);
        reg_addr = region_base(f) + {2'h0, r[6:0], hi};
    endfunction

    mbsf_mem #(
        .AW(mbsf_pkg::MEM_AW)
    ) u_mem (
        .clock(clock),
        .rst(rst),
        .h_ra(mem_ra),
        .h_rd(mem_rd),
        .h_wr(mw),
        .app_wr(app_wr),
        .app_ra(app_ra),
        .app_rd(app_rd)
    );

    // request fields, 16-bit ones assembled high byte first
    assign fc = q.hdr[0];
    assign addr = {q.hdr[1], q.hdr[2]}; // R5
    assign cnt = {q.hdr[3], q.hdr[4]}; // R5
    assign last_item = {1'b0, addr} + {1'b0, cnt} - 17'h00001;
    assign is_bits = (fc == mbsf_pkg::FC_RD_COIL) || (fc == mbsf_pkg::FC_RD_DISC); // R9

    // routing decision, taken on the unit id of the waiting request
    assign gw_en = (server_uid == mbsf_pkg::UID_ALL) && rtu_master_mode; // R1
    assign route = gw_en && req_uid >= mbsf_pkg::UID_MIN && req_uid <= mbsf_pkg::UID_MAX; // R2 R3

    // outputs: response from flops, forward path passes through without a buffer
    assign rsp_valid = q.ov;
    assign rsp_beat = '{data: q.ob, last: q.ol};
    assign fwd_beat = req_beat;

    // next-state logic for the whole handler
    always_comb begin
        logic [7:0] ex;
        logic [7:0] wb;
        logic [7:0] nacc;
        logic [15:0] pos;
        logic lastbit;
        ex = 8'h00;
        wb = 8'h00;
        nacc = q.acc;
        pos = addr + q.item;
        lastbit = (q.item + 16'h0001 == cnt);
        d = q;
        req_ready = 1'b0;
        fwd_valid = 1'b0;
        rtu_ready = 1'b0;
        mw = '0;
        mem_ra = bit_addr(fc, addr);
        if (q.ov && rsp_ready) begin
            d.ov = 1'b0;
        end
        case (q.st)
            mbsf_pkg::S_IDLE: begin
                d.nrx = 3'h0;
                d.idx = 3'h0;
                d.item = 16'h0000;
                d.k = 3'h0;
                d.acc = 8'h00;
                d.hl = 1'b0;
                d.tmr = 32'h0;
                if (req_valid) begin
                    d.st = route ? mbsf_pkg::S_FWD : mbsf_pkg::S_RX; // R1 R2 R3
                end
            end
            mbsf_pkg::S_RX: begin
                req_ready = 1'b1;
                if (req_valid) begin
                    if (q.nrx < mbsf_pkg::PDU_LEN) begin
                        d.hdr[q.nrx] = req_beat.data;
                    end
                    if (q.nrx != 3'h7) begin
                        d.nrx = q.nrx + 3'h1;
                    end
                    if (req_beat.last) begin
                        d.st = mbsf_pkg::S_EXEC;
                    end
                end
            end
            mbsf_pkg::S_EXEC: begin
                case (fc)
                    mbsf_pkg::FC_RD_COIL, mbsf_pkg::FC_RD_DISC: begin // R6 R9
                        if (cnt == 16'h0000 || cnt > mbsf_pkg::MAX_BITS) begin
                            ex = mbsf_pkg::EXC_VALUE;
                        end else if (last_item >= mbsf_pkg::BIT_SPAN) begin
                            ex = mbsf_pkg::EXC_ADDR;
                        end
                    end
                    mbsf_pkg::FC_RD_HOLD, mbsf_pkg::FC_RD_INP: begin // R10 R11
                        if (cnt == 16'h0000 || cnt > mbsf_pkg::MAX_REGS) begin
                            ex = mbsf_pkg::EXC_VALUE;
                        end else if (last_item >= mbsf_pkg::REG_SPAN) begin
                            ex = mbsf_pkg::EXC_ADDR;
                        end
                    end
                    mbsf_pkg::FC_WR_COIL: begin // R13
                        if (cnt != mbsf_pkg::COIL_ON && cnt != mbsf_pkg::COIL_OFF) begin
                            ex = mbsf_pkg::EXC_VALUE;
                        end else if ({1'b0, addr} >= mbsf_pkg::BIT_SPAN) begin
                            ex = mbsf_pkg::EXC_ADDR;
                        end
                    end
                    mbsf_pkg::FC_WR_REG: begin // R15
                        if ({1'b0, addr} >= mbsf_pkg::REG_SPAN) begin
                            ex = mbsf_pkg::EXC_ADDR;
                        end
                    end
                    default: ex = mbsf_pkg::EXC_FUNC; // R18
                endcase
                // a known function with a short or long body is a malformed value
                if (ex == 8'h00 && q.nrx != mbsf_pkg::PDU_LEN) begin
                    ex = mbsf_pkg::EXC_VALUE;
                end
                d.idx = 3'h0;
                if (ex != 8'h00) begin
                    d.exc = ex;
                    d.st = mbsf_pkg::S_EXC;
                end else if (fc == mbsf_pkg::FC_WR_COIL) begin
                    // read-modify-write of the one memory byte
                    wb = mem_rd;
                    wb[addr[2:0]] = (cnt == mbsf_pkg::COIL_ON); // R14
                    mw = '{we: 1'b1, addr: mem_ra, data: wb};
                    d.st = mbsf_pkg::S_ECHO;
                end else if (fc == mbsf_pkg::FC_WR_REG) begin
                    mem_ra = reg_addr(fc, addr, 1'b0);
                    mw = '{we: 1'b1, addr: mem_ra, data: q.hdr[4]}; // R17
                    d.st = mbsf_pkg::S_WR2;
                end else begin
                    d.st = mbsf_pkg::S_HDR;
                end
            end
            mbsf_pkg::S_WR2: begin
                mem_ra = reg_addr(fc, addr, 1'b1);
                mw = '{we: 1'b1, addr: mem_ra, data: q.hdr[3]}; // R17
                d.st = mbsf_pkg::S_ECHO;
            end
            mbsf_pkg::S_HDR: begin
                if (!q.ov) begin
                    d.ov = 1'b1;
                    d.ol = 1'b0;
                    if (q.idx == 3'h0) begin
                        d.ob = fc;
                        d.idx = 3'h1;
                    end else if (is_bits) begin
                        d.ob = 8'((cnt + 16'h0007) >> 3); // R6
                        d.st = mbsf_pkg::S_BITS;
                    end else begin
                        d.ob = {cnt[6:0], 1'b0}; // R10
                        d.st = mbsf_pkg::S_REG;
                    end
                end
            end
            mbsf_pkg::S_BITS: begin
                // one bit per cycle; the slower path keeps one read port
                mem_ra = bit_addr(fc, pos);
                if (!q.ov) begin
                    nacc[q.k] = mem_rd[pos[2:0]]; // R7
                    d.item = q.item + 16'h0001;
                    if (q.k == 3'h7 || lastbit) begin
                        d.ob = nacc; // R8
                        d.ol = lastbit;
                        d.ov = 1'b1;
                        d.acc = 8'h00;
                        d.k = 3'h0;
                        if (lastbit) begin
                            d.st = mbsf_pkg::S_IDLE;
                        end
                    end else begin
                        d.acc = nacc;
                        d.k = q.k + 3'h1;
                    end
                end
            end
            mbsf_pkg::S_REG: begin
                // high byte from the odd address goes out first
                mem_ra = reg_addr(fc, pos, !q.hl); // R10 R12
                if (!q.ov) begin
                    d.ob = mem_rd;
                    d.ov = 1'b1;
                    d.ol = q.hl && lastbit;
                    d.hl = !q.hl;
                    if (q.hl) begin
                        d.item = q.item + 16'h0001;
                        if (lastbit) begin
                            d.st = mbsf_pkg::S_IDLE;
                        end
                    end
                end
            end
            mbsf_pkg::S_ECHO: begin
                if (!q.ov) begin
                    d.ob = q.hdr[q.idx]; // R16
                    d.ol = (q.idx == 3'h4);
                    d.ov = 1'b1;
                    d.idx = q.idx + 3'h1;
                    if (q.idx == 3'h4) begin
                        d.st = mbsf_pkg::S_IDLE;
                    end
                end
            end
            mbsf_pkg::S_EXC: begin
                if (!q.ov) begin
                    d.ov = 1'b1;
                    d.ol = (q.idx != 3'h0);
                    d.idx = 3'h1;
                    if (q.idx == 3'h0) begin
                        d.ob = fc | mbsf_pkg::FC_EXC_FLAG; // R18
                    end else begin
                        d.ob = q.exc;
                        d.st = mbsf_pkg::S_IDLE;
                    end
                end
            end
            mbsf_pkg::S_FWD: begin
                fwd_valid = req_valid; // R2
                req_ready = fwd_ready;
                if (req_valid && fwd_ready) begin
                    if (q.nrx == 3'h0) begin
                        d.hdr[0] = req_beat.data;
                    end
                    d.nrx = 3'h1;
                    if (req_beat.last) begin
                        d.st = mbsf_pkg::S_GWAIT;
                    end
                end
            end
            mbsf_pkg::S_GWAIT: begin
                d.tmr = q.tmr + 32'h1;
                if (rtu_valid) begin
                    d.st = mbsf_pkg::S_GREL;
                end else if (q.tmr == 32'(TIMEOUT_CYC - 1)) begin
                    d.exc = mbsf_pkg::EXC_GW_TIMEOUT; // R4
                    d.idx = 3'h0;
                    d.st = mbsf_pkg::S_EXC;
                end
            end
            mbsf_pkg::S_GREL: begin
                rtu_ready = !q.ov;
                if (rtu_valid && !q.ov) begin
                    d.ob = rtu_beat.data;
                    d.ol = rtu_beat.last;
                    d.ov = 1'b1;
                    if (rtu_beat.last) begin
                        d.st = mbsf_pkg::S_IDLE;
                    end
                end
            end
            default: d.st = mbsf_pkg::S_IDLE;
        endcase
    end

    // state register
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    // checks on routing, timing and byte layout
    gw_route_a: assert property (@(posedge clock) disable iff (rst) // R2
        (q.st == mbsf_pkg::S_IDLE && req_valid && server_uid == 8'hFF && rtu_master_mode
         && req_uid != 8'h00 && req_uid < 8'hF8) |=> q.st == mbsf_pkg::S_FWD)
        else $error("gateway request not forwarded");
    gw_off_a: assert property (@(posedge clock) disable iff (rst) // R1
        (q.st == mbsf_pkg::S_IDLE && req_valid && !rtu_master_mode) |=> q.st == mbsf_pkg::S_RX)
        else $error("forwarded without rtu master");
    local_uid_a: assert property (@(posedge clock) disable iff (rst) // R3
        (q.st == mbsf_pkg::S_IDLE && req_valid && (req_uid == 8'h00 || req_uid == 8'hFF))
        |=> q.st == mbsf_pkg::S_RX)
        else $error("local unit id not served locally");
    gw_timeout_a: assert property (@(posedge clock) disable iff (rst) // R4
        (q.st == mbsf_pkg::S_GWAIT && !rtu_valid && q.tmr == 32'(TIMEOUT_CYC - 1))
        |=> q.st == mbsf_pkg::S_EXC ##1 (rsp_valid && rsp_beat.data == (q.hdr[0] | 8'h80)))
        else $error("timeout without error response");
    bad_func_a: assert property (@(posedge clock) disable iff (rst) // R18
        (q.st == mbsf_pkg::S_EXEC && (fc == 8'h00 || fc > 8'h06))
        |=> q.st == mbsf_pkg::S_EXC && q.exc == 8'h01)
        else $error("unknown function not refused");
    reg_write_a: assert property (@(posedge clock) disable iff (rst) // R17
        (q.st == mbsf_pkg::S_EXEC && mw.we && fc == 8'h06)
        |-> mw.data == q.hdr[4] && !mw.addr[0]
        ##1 (mw.we && mw.data == q.hdr[3] && mw.addr == $past(mw.addr) + 10'h001))
        else $error("register bytes written out of order");
    coil_write_a: assert property (@(posedge clock) disable iff (rst) // R14
        (q.st == mbsf_pkg::S_EXEC && mw.we && fc == 8'h05)
        |-> mw.data[addr[2:0]] == (cnt == 16'hFF00))
        else $error("coil value not applied");
    echo_a: assert property (@(posedge clock) disable iff (rst) // R16
        (q.st == mbsf_pkg::S_ECHO && !q.ov) |=> rsp_valid && rsp_beat.data == q.hdr[$past(q.idx)])
        else $error("write answer differs from request");
    pad_zero_a: assert property (@(posedge clock) disable iff (rst) // R8
        (q.st == mbsf_pkg::S_BITS && !q.ov && lastbit_w && q.k != 3'h7)
        |=> (rsp_beat.data >> ($past(q.k) + 3'h1)) == 8'h00)
        else $error("unused coil bits not zero");
    reg_hi_first_a: assert property (@(posedge clock) disable iff (rst) // R10
        (q.st == mbsf_pkg::S_REG && !q.ov && !q.hl) |-> mem_ra[0] ##1 rsp_beat.data == $past(mem_rd))
        else $error("register low byte sent first");

    // last-item flag seen by the padding check
    assign lastbit_w = (q.item + 16'h0001 == cnt);
endmodule

// File: mbsf_handler_test.sv
// self-checking bench for the server function handler
// assumes the slave model on the forward side and the app port for memory setup
`timescale 1ns/1ps
module mbsf_handler_test;
    logic clock = 1'b0;
    logic rst = 1'b1;
    logic [7:0] server_uid = 8'h01;
    logic rtu_master_mode = 1'b0;
    logic req_valid = 1'b0;
    logic [7:0] req_uid = 8'h00;
    logic answer = 1'b1;
    logic [9:0] app_ra = '0;
    logic req_ready, rsp_valid, fwd_valid, fwd_ready, rtu_valid, rtu_ready, got_last;
    logic [7:0] app_rd;
    logic [7:0] got[$];
    mbsf_pkg::mbsf_beat_t req_beat = '0;
    mbsf_pkg::mbsf_beat_t rsp_beat, fwd_beat, rtu_beat;
    mbsf_pkg::mbsf_wr_t app_wr = '0;
    int errors = 0;
    int check_count = 0;

    mbsf_handler #(.TIMEOUT_CYC(50)) u_dut (.clock(clock), .rst(rst), .server_uid(server_uid),
        .rtu_master_mode(rtu_master_mode), .req_valid(req_valid), .req_ready(req_ready),
        .req_beat(req_beat), .req_uid(req_uid), .rsp_valid(rsp_valid), .rsp_ready(1'b1),
        .rsp_beat(rsp_beat), .fwd_valid(fwd_valid), .fwd_ready(fwd_ready), .fwd_beat(fwd_beat),
        .rtu_valid(rtu_valid), .rtu_ready(rtu_ready), .rtu_beat(rtu_beat), .app_wr(app_wr),
        .app_ra(app_ra), .app_rd(app_rd));
    mbsf_slave_model u_slave (.clock(clock), .fwd_valid(fwd_valid), .fwd_ready(fwd_ready),
        .fwd_beat(fwd_beat), .rtu_valid(rtu_valid), .rtu_ready(rtu_ready), .rtu_beat(rtu_beat),
        .answer(answer));

    // 25 MHz clock
    always #20 clock = ~clock;

    // a byte stands one cycle with ready held high, so sample mid-cycle
    always @(negedge clock) begin
        if (rsp_valid === 1'b1) begin
            got.push_back(rsp_beat.data);
            got_last = rsp_beat.last;
        end
    end

    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        check_count++;
        if (g !== e) begin
            errors++;
            $display("FAIL %0t got %h expected %h", $time, g, e);
        end
    endtask

    // one request in, whole response compared; holds valid until ready seen before the edge
    task automatic txn(input logic [7:0] uid, input logic [7:0] rq[$], input logic [7:0] ex[$]);
        int i;
        @(negedge clock);
        got = {};
        got_last = 1'b0;
        req_uid = uid;
        for (i = 0; i < rq.size(); i++) begin
            @(negedge clock);
            req_valid = 1'b1;
            req_beat = '{data: rq[i], last: i == rq.size() - 1};
            #19;
            while (req_ready !== 1'b1) begin
                @(negedge clock);
                #19;
            end
        end
        @(negedge clock);
        req_valid = 1'b0;
        req_beat.data = ~req_beat.data;
        for (i = 0; i < 300 && got_last !== 1'b1; i++) @(negedge clock);
        chk(8'(got.size()), 8'(ex.size()));
        chk({7'h00, got_last}, 8'h01);
        foreach (ex[j]) chk(got[j], ex[j]);
    endtask

    task automatic aw(input logic [9:0] a, input logic [7:0] d);
        @(negedge clock);
        app_wr = '{we: 1'b1, addr: a, data: d};
        @(negedge clock);
        app_wr.we = 1'b0;
    endtask

    task automatic ar(input logic [9:0] a, input logic [7:0] e);
        @(negedge clock);
        app_ra = a;
        @(negedge clock);
        chk(app_rd, e);
    endtask

    task automatic t_words;
        txn(8'h00, '{8'h06, 8'h00, 8'h01, 8'h12, 8'h34}, '{8'h06, 8'h00, 8'h01, 8'h12, 8'h34});
        ar(mbsf_pkg::HOLD_BASE + 10'h002, 8'h34);
        ar(mbsf_pkg::HOLD_BASE + 10'h003, 8'h12);
        aw(mbsf_pkg::HOLD_BASE + 10'h004, 8'h78);
        aw(mbsf_pkg::HOLD_BASE + 10'h005, 8'h56);
        txn(8'h00, '{8'h03, 8'h00, 8'h01, 8'h00, 8'h02}, '{8'h03, 8'h04, 8'h12, 8'h34, 8'h56, 8'h78});
        aw(mbsf_pkg::INP_BASE, 8'h11);
        aw(mbsf_pkg::INP_BASE + 10'h001, 8'h22);
        txn(8'h00, '{8'h04, 8'h00, 8'h00, 8'h00, 8'h01}, '{8'h04, 8'h02, 8'h22, 8'h11});
        txn(8'h00, '{8'h03, 8'h00, 8'h7F, 8'h00, 8'h02}, '{8'h83, 8'h02});
        txn(8'h00, '{8'h06, 8'h00, 8'h01, 8'h12}, '{8'h86, 8'h03});
        txn(8'h00, '{8'h01, 8'h00, 8'h00, 8'h00, 8'h00}, '{8'h81, 8'h03});
        $display("test words done");
    endtask

    task automatic t_bits;
        aw(mbsf_pkg::COIL_BASE + 10'h001, 8'h81);
        aw(mbsf_pkg::COIL_BASE + 10'h002, 8'hFF);
        aw(mbsf_pkg::DISC_BASE + 10'h001, 8'h3C);
        aw(mbsf_pkg::DISC_BASE + 10'h002, 8'hFF);
        txn(8'h00, '{8'h05, 8'h00, 8'h0A, 8'hFF, 8'h00}, '{8'h05, 8'h00, 8'h0A, 8'hFF, 8'h00});
        txn(8'h00, '{8'h05, 8'h00, 8'h0B, 8'h12, 8'h34}, '{8'h85, 8'h03});
        txn(8'h00, '{8'h01, 8'h00, 8'h08, 8'h00, 8'h0B}, '{8'h01, 8'h02, 8'h85, 8'h07});
        txn(8'h00, '{8'h02, 8'h00, 8'h08, 8'h00, 8'h0B}, '{8'h02, 8'h02, 8'h3C, 8'h07});
        txn(8'h00, '{8'h05, 8'h00, 8'h0F, 8'h00, 8'h00}, '{8'h05, 8'h00, 8'h0F, 8'h00, 8'h00});
        ar(mbsf_pkg::COIL_BASE + 10'h001, 8'h05);
        txn(8'h00, '{8'h07, 8'h00, 8'h00, 8'h00, 8'h00}, '{8'h87, 8'h01});
        $display("test bits done");
    endtask

    task automatic t_gateway;
        server_uid = 8'hFF;
        rtu_master_mode = 1'b1;
        txn(8'h05, '{8'h03, 8'h00, 8'h00, 8'h00, 8'h01}, '{8'h03, 8'h5A, 8'hC3});
        chk(8'(u_slave.seen.size()), 8'h05);
        txn(8'hFF, '{8'h07, 8'h00, 8'h00, 8'h00, 8'h00}, '{8'h87, 8'h01});
        answer = 1'b0;
        txn(8'hF7, '{8'h03, 8'h00, 8'h00, 8'h00, 8'h01}, '{8'h83, 8'h0B});
        rtu_master_mode = 1'b0;
        txn(8'h05, '{8'h07, 8'h00, 8'h00, 8'h00, 8'h00}, '{8'h87, 8'h01});
        chk(8'(u_slave.seen.size()), 8'h0A);
        $display("test gateway done");
    endtask

    task automatic results;
        $display("checks %0d errors %0d", check_count, errors);
        if (errors == 0 && check_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // main sequence
    initial begin
        repeat (3) @(negedge clock);
        rst = 1'b0;
        t_words();
        t_bits();
        t_gateway();
        results();
    end

    // watchdog at 10000 cycles, far beyond the few hundred cycles the tests need
    initial begin
        #400000;
        errors++;
        results();
    end
endmodule

// File: mbsf_mem.sv
// marker memory: one combinational read port for the handler, one clocked for the app
// assumes writers on the same clock; handler write wins a same-address clash
`timescale 1ns/1ps
module mbsf_mem #(
    parameter int AW = mbsf_pkg::MEM_AW
) (
    // clock and reset
    input logic clock,
    input logic rst,
    // handler side
    input logic [AW-1:0] h_ra,
    output logic [7:0] h_rd,
    input mbsf_pkg::mbsf_wr_t h_wr,
    // application side
    input mbsf_pkg::mbsf_wr_t app_wr,
    input logic [AW-1:0] app_ra,
    output logic [7:0] app_rd
);
    logic [7:0] mem [2**AW];

    // byte writes, handler first so a request is never half lost
    always_ff @(posedge clock) begin
        if (h_wr.we) begin
            mem[h_wr.addr] <= h_wr.data;
        end
        if (app_wr.we && !(h_wr.we && h_wr.addr == app_wr.addr)) begin
            mem[app_wr.addr] <= app_wr.data;
        end
    end

    // application read, registered so it reads clean from reset
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            app_rd <= 8'h00;
        end else begin
            app_rd <= mem[app_ra];
        end
    end

    assign h_rd = mem[h_ra];
endmodule

// File: mbsf_pkg.sv
// shared constants, enums and carrier structs for the server function handler
// assumes one 25 MHz clock and a byte-addressed marker memory behind the handler
package mbsf_pkg;
    // clock and gateway timing
    localparam int CLK_MHZ = 25;
    localparam int GW_TIMEOUT_US = 100000;
    localparam int GW_TIMEOUT_CYC = GW_TIMEOUT_US * CLK_MHZ;

    // marker memory layout, byte offsets of the four data regions
    localparam int MEM_AW = 10;
    localparam logic [9:0] COIL_BASE = 10'h000;
    localparam logic [9:0] DISC_BASE = 10'h100;
    localparam logic [9:0] HOLD_BASE = 10'h200;
    localparam logic [9:0] INP_BASE = 10'h300;
    localparam logic [16:0] BIT_SPAN = 17'h00800;
    localparam logic [16:0] REG_SPAN = 17'h00080;
    localparam logic [15:0] MAX_BITS = 16'h07D0;
    localparam logic [15:0] MAX_REGS = 16'h007D;

    // field values
    localparam logic [15:0] COIL_ON = 16'hFF00;
    localparam logic [15:0] COIL_OFF = 16'h0000;
    localparam logic [7:0] UID_ALL = 8'hFF;
    localparam logic [7:0] UID_MIN = 8'h01;
    localparam logic [7:0] UID_MAX = 8'hF7;
    localparam logic [2:0] PDU_LEN = 3'h5;

    // function and exception codes
    localparam logic [7:0] FC_RD_COIL = 8'h01;
    localparam logic [7:0] FC_RD_DISC = 8'h02;
    localparam logic [7:0] FC_RD_HOLD = 8'h03;
    localparam logic [7:0] FC_RD_INP = 8'h04;
    localparam logic [7:0] FC_WR_COIL = 8'h05;
    localparam logic [7:0] FC_WR_REG = 8'h06;
    localparam logic [7:0] FC_EXC_FLAG = 8'h80;
    localparam logic [7:0] EXC_FUNC = 8'h01;
    localparam logic [7:0] EXC_ADDR = 8'h02;
    localparam logic [7:0] EXC_VALUE = 8'h03;
    localparam logic [7:0] EXC_GW_TIMEOUT = 8'h0B;

    typedef enum logic [3:0] {
        S_IDLE = 4'h0,
        S_RX = 4'h1,
        S_EXEC = 4'h2,
        S_WR2 = 4'h3,
        S_HDR = 4'h4,
        S_BITS = 4'h5,
        S_REG = 4'h6,
        S_ECHO = 4'h7,
        S_EXC = 4'h8,
        S_FWD = 4'h9,
        S_GWAIT = 4'hA,
        S_GREL = 4'hB
    } mbsf_state_t;

    // one byte of a stream with its end marker
    typedef struct packed {
        logic [7:0] data;
        logic last;
    } mbsf_beat_t;

    // one memory byte write
    typedef struct packed {
        logic we;
        logic [MEM_AW-1:0] addr;
        logic [7:0] data;
    } mbsf_wr_t;

    // complete handler state
    typedef struct packed {
        mbsf_state_t st;
        logic [4:0][7:0] hdr;
        logic [2:0] nrx;
        logic [7:0] exc;
        logic [2:0] idx;
        logic [15:0] item;
        logic [2:0] k;
        logic [7:0] acc;
        logic hl;
        logic [7:0] ob;
        logic ol;
        logic ov;
        logic [31:0] tmr;
    } mbsf_regs_t;
endpackage

// File: mbsf_slave_model.sv
// rtu slave stand-in behind the gateway: logs forwarded bytes, answers or stays silent
// assumes the handler forward and relay handshakes on one rising-edge clock
`timescale 1ns/1ps
module mbsf_slave_model (
    // clock
    input logic clock,
    // forwarded request
    input logic fwd_valid,
    output logic fwd_ready,
    input mbsf_pkg::mbsf_beat_t fwd_beat,
    // slave reply
    output logic rtu_valid,
    input logic rtu_ready,
    output mbsf_pkg::mbsf_beat_t rtu_beat,
    // control from the bench
    input logic answer
);
    logic [7:0] seen[$];
    logic [7:0] rep[3];
    int n;
    // reply fc of the first forwarded request, 5A, C3 after a short delay; silence lets the gateway time out
    initial begin
        fwd_ready = 1'b1;
        rtu_valid = 1'b0;
        rtu_beat = '0;
        forever begin
            @(posedge clock);
            if (fwd_valid === 1'b1) begin
                seen.push_back(fwd_beat.data);
                if (fwd_beat.last && answer) begin
                    rep = '{seen[0], 8'h5A, 8'hC3};
                    repeat (3) @(posedge clock);
                    for (n = 0; n < 3; n++) begin
                        #1 rtu_valid = 1'b1;
                        rtu_beat = '{data: rep[n], last: n == 2};
                        do @(posedge clock); while (rtu_ready !== 1'b1);
                    end
                    // released line shows the inverse, never a stale copy
                    #1 rtu_valid = 1'b0;
                    rtu_beat.data = ~rtu_beat.data;
                end
            end
        end
    end
endmodule
